// >>> hbsf_device.sv
`timescale 1ns/1ps
`include "hbsf_defines.svh"
module hbsf_device
  import hbsf_pkg::*;
#(
  parameter bit HAS_SLEEP_PIN = 1'b1,
  parameter int CNT_W = `HBSF_CNT_W,
  parameter logic [CNT_W-1:0] SLEEP_CYC = CNT_W'(`HBSF_SLEEP_CYC),
  parameter logic [CNT_W-1:0] WAKE_CYC = CNT_W'(`HBSF_WAKE_CYC),
  parameter logic [CNT_W-1:0] RETRY_CYC = CNT_W'(`HBSF_RETRY_CYC)
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // link to the host
  hbsf_link_if.device link,
  // analog fault flags
  input wire logic overtemp_shutdown,
  input wire logic overtemp_hysteresis,
  input wire logic supply_low_lockout,
  input wire logic overcurrent_trip,
  // status
  output hbsf_pkg::hbsf_state_e device_state,
  output logic fault_active
);
  import hbsf_pkg::*;

  typedef struct packed {
    hbsf_state_e state;
    logic ot_latched;
    logic oc_retry;
    hbsf_out_e out_a;
    hbsf_out_e out_b;
    logic fault;
  } hbsf_dev_s;
  hbsf_dev_s st;
  hbsf_dev_s next_st;

  logic sleep_pin_low;
  logic idle_req;
  logic wake_req;
  logic idle_done;
  logic wake_done;
  logic retry_done;
  hbsf_out_e dec_a;
  hbsf_out_e dec_b;

  // ************************************************************
  // input decode
  // ************************************************************
  // no-pin variant
  assign sleep_pin_low = HAS_SLEEP_PIN ? !link.sleep_request_low : 1'b0;
  always_comb begin
    dec_a = HBSF_OUT_HIZ;
    dec_b = HBSF_OUT_HIZ;
    idle_req = 1'b0;
    unique case (link.mode_select)
      HBSF_IF_PHEN: begin
        if (!link.control_input_b) begin
          dec_a = HBSF_OUT_LOW;
          dec_b = HBSF_OUT_LOW;
          idle_req = 1'b1;
        end else if (link.control_input_a) begin
          dec_a = HBSF_OUT_HIGH;
          dec_b = HBSF_OUT_LOW;
        end else begin
          dec_a = HBSF_OUT_LOW;
          dec_b = HBSF_OUT_HIGH;
        end
      end
      HBSF_IF_HALF: begin
        dec_a = link.control_input_a ? HBSF_OUT_HIGH : HBSF_OUT_LOW;
        dec_b = link.control_input_b ? HBSF_OUT_HIGH : HBSF_OUT_LOW;
      end
      default: begin
        unique case ({link.control_input_a, link.control_input_b})
          2'b10: begin
            dec_a = HBSF_OUT_HIGH;
            dec_b = HBSF_OUT_LOW;
          end
          2'b01: begin
            dec_a = HBSF_OUT_LOW;
            dec_b = HBSF_OUT_HIGH;
          end
          2'b11: begin
            dec_a = HBSF_OUT_LOW;
            dec_b = HBSF_OUT_LOW;
          end
          default: begin
            idle_req = 1'b1;
          end
        endcase
      end
    endcase
  end
  // wake needs inputs out of the idle states
  assign wake_req = !sleep_pin_low && !idle_req;

  // ************************************************************
  // timers
  // ************************************************************
  // idle timer
  hbsf_timer #(.CNT_W(CNT_W)) u_idle_tmr (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(st.state == HBSF_ST_IDLE && idle_req),
    .limit(SLEEP_CYC),
    .done(idle_done)
  );
  hbsf_timer #(.CNT_W(CNT_W)) u_wake_tmr (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(st.state == HBSF_ST_WAKE && wake_req),
    .limit(WAKE_CYC),
    .done(wake_done)
  );
  hbsf_timer #(.CNT_W(CNT_W)) u_retry_tmr (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(st.oc_retry),
    .limit(RETRY_CYC),
    .done(retry_done)
  );

  // ************************************************************
  // mode and fault sequencing
  // ************************************************************
  always_comb begin
    next_st = st;
    if (overtemp_shutdown) begin
      next_st.ot_latched = 1'b1;
    end else if (!overtemp_hysteresis) begin
      next_st.ot_latched = 1'b0;
    end
    // retry window runs from the first trip cycle and does not restart while trip persists
    if (overcurrent_trip) begin
      next_st.oc_retry = 1'b1;
    end else if (retry_done) begin
      next_st.oc_retry = 1'b0;
    end
    unique case (st.state)
      // active leaves only to sleep, idle or fault
      HBSF_ST_ACTIVE: begin
        if (sleep_pin_low) begin
          next_st.state = HBSF_ST_SLEEP;
        end else if (idle_req) begin
          next_st.state = HBSF_ST_IDLE;
        end
      end
      HBSF_ST_IDLE: begin
        if (sleep_pin_low) begin
          next_st.state = HBSF_ST_SLEEP;
        end else if (!idle_req) begin
          next_st.state = HBSF_ST_ACTIVE;
        end else if (idle_done) begin
          next_st.state = HBSF_ST_SLEEP;
        end
      end
      HBSF_ST_SLEEP: begin
        if (wake_req) begin
          next_st.state = HBSF_ST_WAKE;
        end
      end
      HBSF_ST_WAKE: begin
        if (!wake_req) begin
          next_st.state = HBSF_ST_SLEEP;
        end else if (wake_done) begin
          next_st.state = HBSF_ST_ACTIVE;
        end
      end
      HBSF_ST_FAULT: begin
        // sleep pin still wins on recovery
        if (sleep_pin_low) begin
          next_st.state = HBSF_ST_SLEEP;
        end else begin
          next_st.state = HBSF_ST_ACTIVE;
        end
      end
      default: begin
        next_st.state = HBSF_ST_ACTIVE;
      end
    endcase
    if (supply_low_lockout || next_st.ot_latched || next_st.oc_retry) begin
      next_st.state = HBSF_ST_FAULT;
    end
    // output selection
    next_st.out_a = dec_a;
    next_st.out_b = dec_b;
    unique case (next_st.state)
      HBSF_ST_ACTIVE: begin
        next_st.out_a = dec_a;
      end
      HBSF_ST_IDLE: begin
        next_st.out_a = dec_a;
      end
      default: begin
        next_st.out_a = HBSF_OUT_HIZ;
        next_st.out_b = HBSF_OUT_HIZ;
      end
    endcase
    // fault status kept in a flop of its own
    next_st.fault = (next_st.state == HBSF_ST_FAULT);
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st.state <= HBSF_ST_ACTIVE;
      st.ot_latched <= 1'b0;
      st.oc_retry <= 1'b0;
      st.out_a <= HBSF_OUT_HIZ;
      st.out_b <= HBSF_OUT_HIZ;
      st.fault <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // registered outputs
  assign link.bridge_output_a = st.out_a;
  assign link.bridge_output_b = st.out_b;
  assign device_state = st.state;
  assign fault_active = st.fault;
endmodule // hbsf_device

// >>> hbsf_defines.svh
`ifndef HBSF_DEFINES_SVH
`define HBSF_DEFINES_SVH
// timing figures in microseconds, clock in MHz
`define HBSF_SLEEP_US 1000
`define HBSF_WAKE_US 100
`define HBSF_RETRY_US 2000
`define HBSF_CLK_MHZ 200
// cycle counts derived from the figures (microseconds times clock MHz, exact)
`define HBSF_SLEEP_CYC (`HBSF_SLEEP_US * `HBSF_CLK_MHZ)
`define HBSF_WAKE_CYC (`HBSF_WAKE_US * `HBSF_CLK_MHZ)
`define HBSF_RETRY_CYC (`HBSF_RETRY_US * `HBSF_CLK_MHZ)
`define HBSF_CNT_W 20
`endif

// >>> hbsf_pkg.sv
package hbsf_pkg;
  // interface select decoded from the tri-level input
  typedef enum logic [1:0] {
    HBSF_IF_PWM = 2'b00,
    HBSF_IF_PHEN = 2'b01,
    HBSF_IF_HALF = 2'b10
  } hbsf_if_e;
  // per-output drive state
  typedef enum logic [1:0] {
    HBSF_OUT_HIZ = 2'b00,
    HBSF_OUT_LOW = 2'b01,
    HBSF_OUT_HIGH = 2'b10
  } hbsf_out_e;
  // device operating state, gray along active->idle->sleep->wake
  typedef enum logic [2:0] {
    HBSF_ST_ACTIVE = 3'b000,
    HBSF_ST_IDLE = 3'b001,
    HBSF_ST_SLEEP = 3'b011,
    HBSF_ST_WAKE = 3'b010,
    HBSF_ST_FAULT = 3'b110
  } hbsf_state_e;
endpackage

// >>> hbsf_link_if.sv
`timescale 1ns/1ps
interface hbsf_link_if;
  logic sleep_request_low;
  logic control_input_a;
  logic control_input_b;
  hbsf_pkg::hbsf_if_e mode_select;
  hbsf_pkg::hbsf_out_e bridge_output_a;
  hbsf_pkg::hbsf_out_e bridge_output_b;
  modport device (
    input sleep_request_low, control_input_a, control_input_b, mode_select,
    output bridge_output_a, bridge_output_b
  );
  modport host (
    output sleep_request_low, control_input_a, control_input_b, mode_select,
    input bridge_output_a, bridge_output_b
  );
endinterface

// >>> hbsf_timer.sv
`timescale 1ns/1ps
`include "hbsf_defines.svh"
module hbsf_timer #(
  parameter int CNT_W = `HBSF_CNT_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // control
  input wire logic run,
  input wire logic [CNT_W-1:0] limit,
  // status
  output logic done
);
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic done;
  } hbsf_tmr_s;
  hbsf_tmr_s st;
  hbsf_tmr_s next_st;
  // count while run holds, flag once limit reached
  always_comb begin
    next_st = st;
    if (!run) begin
      next_st.count = '0;
      next_st.done = 1'b0;
    end else if (st.count >= limit - 1'b1) begin
      next_st.done = 1'b1;
    end else begin
      next_st.count = st.count + 1'b1;
    end
  end
  // state register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign done = st.done;
endmodule // hbsf_timer

// >>> hbsf_host.sv
`timescale 1ns/1ps
`include "hbsf_defines.svh"
module hbsf_host
  import hbsf_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // link to the device
  hbsf_link_if.host link,
  // user side
  input wire logic user_sleep,
  input wire hbsf_pkg::hbsf_if_e user_mode,
  input wire logic user_in_a,
  input wire logic user_in_b,
  output hbsf_pkg::hbsf_out_e seen_output_a,
  output hbsf_pkg::hbsf_out_e seen_output_b
);
  import hbsf_pkg::*;

  typedef struct packed {
    logic sleep_n;
    hbsf_if_e mode;
    logic in_a;
    logic in_b;
    hbsf_out_e seen_a;
    hbsf_out_e seen_b;
  } hbsf_host_s;
  hbsf_host_s st;
  hbsf_host_s next_st;

  // register pins; inputs forced low while sleeping
  always_comb begin
    next_st = st;
    next_st.sleep_n = !user_sleep;
    next_st.mode = user_mode;
    next_st.in_a = user_sleep ? 1'b0 : user_in_a;
    next_st.in_b = user_sleep ? 1'b0 : user_in_b;
    next_st.seen_a = link.bridge_output_a;
    next_st.seen_b = link.bridge_output_b;
  end

  // state register, starts asleep with inputs low
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st.sleep_n <= 1'b0;
      st.mode <= HBSF_IF_PWM;
      st.in_a <= 1'b0;
      st.in_b <= 1'b0;
      st.seen_a <= HBSF_OUT_HIZ;
      st.seen_b <= HBSF_OUT_HIZ;
    end else begin
      st <= next_st;
    end
  end

  assign link.sleep_request_low = st.sleep_n;
  assign link.mode_select = st.mode;
  assign link.control_input_a = st.in_a;
  assign link.control_input_b = st.in_b;
  assign seen_output_a = st.seen_a;
  assign seen_output_b = st.seen_b;
endmodule // hbsf_host

// >>> hbsf_link_sva.sv
`timescale 1ns/1ps
module hbsf_link_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // link
  input wire logic sleep_request_low,
  input wire logic control_input_a,
  input wire logic control_input_b,
  input wire hbsf_pkg::hbsf_if_e mode_select,
  input wire hbsf_pkg::hbsf_out_e bridge_output_a,
  input wire hbsf_pkg::hbsf_out_e bridge_output_b,
  // device status and flags
  input wire hbsf_pkg::hbsf_state_e device_state,
  input wire logic fault_active,
  input wire logic overtemp_shutdown,
  input wire logic overtemp_hysteresis,
  input wire logic supply_low_lockout,
  input wire logic overcurrent_trip
);
  import hbsf_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic go;
  logic hiz;
  logic pa;
  logic pb;
  // awake, no fault, decoding inputs
  assign go = sleep_request_low && device_state == HBSF_ST_ACTIVE && !fault_active &&
    !overtemp_shutdown && !supply_low_lockout && !overcurrent_trip;
  assign hiz = bridge_output_a == HBSF_OUT_HIZ && bridge_output_b == HBSF_OUT_HIZ;
  // inputs one cycle back
  always_ff @(posedge clk_sys) begin
    pa <= control_input_a;
    pb <= control_input_b;
  end
  chk_pin_sleep: assert property (!sleep_request_low |=> hiz)
    else $error("outputs driven while sleep pin low");
  chk_fault_off: assert property (
    (overtemp_shutdown || supply_low_lockout || overcurrent_trip) |=> hiz && fault_active)
    else $error("bridge driven during fault");
  chk_hyst_hold: assert property (fault_active && overtemp_hysteresis |=> fault_active)
    else $error("overtemp released above hysteresis");
  chk_pwm_drive: assert property (go && mode_select == HBSF_IF_PWM &&
    (control_input_a || control_input_b) |=>
    bridge_output_a == (pa && !pb ? HBSF_OUT_HIGH : HBSF_OUT_LOW) &&
    bridge_output_b == (!pa && pb ? HBSF_OUT_HIGH : HBSF_OUT_LOW))
    else $error("pwm decode wrong");
  chk_pwm_coast: assert property (go && mode_select == HBSF_IF_PWM &&
    !control_input_a && !control_input_b |=> hiz)
    else $error("pwm coast not hiz");
  chk_phen_drive: assert property (go && mode_select == HBSF_IF_PHEN &&
    control_input_b |=>
    bridge_output_a == (pa ? HBSF_OUT_HIGH : HBSF_OUT_LOW) &&
    bridge_output_b == (pa ? HBSF_OUT_LOW : HBSF_OUT_HIGH))
    else $error("phase enable drive wrong");
  chk_phen_brake: assert property (go && mode_select == HBSF_IF_PHEN &&
    !control_input_b |=>
    bridge_output_a == HBSF_OUT_LOW && bridge_output_b == HBSF_OUT_LOW)
    else $error("phase enable brake wrong");
  chk_half_follow: assert property (go && mode_select == HBSF_IF_HALF |=>
    bridge_output_a == (pa ? HBSF_OUT_HIGH : HBSF_OUT_LOW) &&
    bridge_output_b == (pb ? HBSF_OUT_HIGH : HBSF_OUT_LOW) &&
    device_state == HBSF_ST_ACTIVE)
    else $error("half bridge outputs wrong");
  cov_autosleep: cover property (device_state == HBSF_ST_SLEEP && sleep_request_low);
  cov_recover: cover property (fault_active ##1 !fault_active);
  cov_mode_change: cover property (go && $changed(mode_select));
endmodule // hbsf_link_sva

// >>> hbridge_sleep_fault_control_tb.sv
`timescale 1ns/1ps
module hbridge_sleep_fault_control_tb;
  import hbsf_pkg::*;
  localparam int T = 8;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic user_sleep = 1'b0;
  logic user_in_a = 1'b0;
  logic user_in_b = 1'b0;
  hbsf_if_e user_mode = HBSF_IF_PWM;
  hbsf_if_e m;
  logic overtemp_shutdown = 1'b0;
  logic overtemp_hysteresis = 1'b0;
  logic supply_low_lockout = 1'b0;
  logic overcurrent_trip = 1'b0;
  hbsf_out_e seen_output_a;
  hbsf_out_e seen_output_b;
  hbsf_state_e device_state;
  logic fault_active;
  int num_errors = 0;
  int n_compared = 0;
  int seed = 63;
  logic [31:0] r;
  logic [3:0] exp_q[$];
  logic [3:0] e;
  hbsf_link_if hbsf_link_if_i ();
  hbsf_device #(.SLEEP_CYC(20'h8), .WAKE_CYC(20'h8), .RETRY_CYC(20'h8)) hbsf_device_i (
    .clk_sys(clk_sys), .reset(reset), .link(hbsf_link_if_i),
    .overtemp_shutdown(overtemp_shutdown), .overtemp_hysteresis(overtemp_hysteresis),
    .supply_low_lockout(supply_low_lockout), .overcurrent_trip(overcurrent_trip),
    .device_state(device_state), .fault_active(fault_active));
  hbsf_host hbsf_host_i (
    .clk_sys(clk_sys), .reset(reset), .link(hbsf_link_if_i), .user_sleep(user_sleep),
    .user_mode(user_mode), .user_in_a(user_in_a), .user_in_b(user_in_b),
    .seen_output_a(seen_output_a), .seen_output_b(seen_output_b));
  hbsf_link_sva hbsf_link_sva_i (
    .clk_sys(clk_sys), .reset(reset),
    .sleep_request_low(hbsf_link_if_i.sleep_request_low),
    .control_input_a(hbsf_link_if_i.control_input_a),
    .control_input_b(hbsf_link_if_i.control_input_b),
    .mode_select(hbsf_link_if_i.mode_select),
    .bridge_output_a(hbsf_link_if_i.bridge_output_a),
    .bridge_output_b(hbsf_link_if_i.bridge_output_b),
    .device_state(device_state), .fault_active(fault_active),
    .overtemp_shutdown(overtemp_shutdown), .overtemp_hysteresis(overtemp_hysteresis),
    .supply_low_lockout(supply_low_lockout), .overcurrent_trip(overcurrent_trip));
  // second device without the sleep pin, fed the same host pins
  hbsf_link_if nopin_link_if_i ();
  hbsf_state_e nopin_state;
  assign nopin_link_if_i.sleep_request_low = hbsf_link_if_i.sleep_request_low;
  assign nopin_link_if_i.control_input_a = hbsf_link_if_i.control_input_a;
  assign nopin_link_if_i.control_input_b = hbsf_link_if_i.control_input_b;
  assign nopin_link_if_i.mode_select = hbsf_link_if_i.mode_select;
  hbsf_device #(.HAS_SLEEP_PIN(1'b0), .SLEEP_CYC(20'h8), .WAKE_CYC(20'h8), .RETRY_CYC(20'h8))
      hbsf_device_nopin_i (
    .clk_sys(clk_sys), .reset(reset), .link(nopin_link_if_i),
    .overtemp_shutdown(overtemp_shutdown), .overtemp_hysteresis(overtemp_hysteresis),
    .supply_low_lockout(supply_low_lockout), .overcurrent_trip(overcurrent_trip),
    .device_state(nopin_state), .fault_active());
  always #2.5 clk_sys = ~clk_sys;
  // compare and count
  task automatic check(input logic [3:0] seen, input logic [3:0] want);
    n_compared++;
    if (seen !== want) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  // verdict and end of run
  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // expected outputs a,b for awake decode
  function automatic logic [3:0] want(input hbsf_if_e md, input logic a, input logic b);
    case (md)
      HBSF_IF_PWM: want = (a == b) ? (a ? 4'h5 : 4'h0) : (a ? 4'h9 : 4'h6);
      HBSF_IF_PHEN: want = !b ? 4'h5 : (a ? 4'h9 : 4'h6);
      default: want = {a ? 2'h2 : 2'h1, b ? 2'h2 : 2'h1};
    endcase
  endfunction
  // drive user side, wait, note expected outputs
  task automatic drive(input logic sl, input hbsf_if_e md, input logic a, input logic b,
      input int n, input logic [3:0] x);
    user_sleep <= sl;
    user_mode <= md;
    user_in_a <= a;
    user_in_b <= b;
    repeat (n) @(posedge clk_sys);
    exp_q.push_back(x);
  endtask
  // monitor takes oldest note
  always @(negedge clk_sys) begin
    if (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check({seen_output_a, seen_output_b}, e);
    end
  end
  // watchdog
  initial begin
    #50000;
    num_errors++;
    wrap_up();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    drive(0, HBSF_IF_PWM, 1, 0, T + 10, 4'h9);
    // random decode, forward between so no idle run reaches the timer
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      m = (r[1:0] == 2'h3) ? HBSF_IF_HALF : hbsf_if_e'(r[1:0]);
      drive(0, m, r[2], r[3], 5, want(m, r[2], r[3]));
      drive(0, HBSF_IF_PWM, 1, 0, 5, 4'h9);
    end
    drive(0, HBSF_IF_PWM, 0, 0, T + 8, 4'h0);
    check({1'h0, device_state}, {1'h0, HBSF_ST_SLEEP});
    drive(0, HBSF_IF_PWM, 1, 0, 3, 4'h0);
    drive(0, HBSF_IF_PWM, 1, 0, T + 8, 4'h9);
    drive(0, HBSF_IF_PHEN, 0, 0, 5, 4'h5);
    drive(0, HBSF_IF_PHEN, 0, 0, T + 6, 4'h0);
    drive(0, HBSF_IF_PHEN, 1, 1, T + 10, 4'h9);
    drive(1, HBSF_IF_PHEN, 1, 1, 4, 4'h0);
    check({1'h0, device_state}, {1'h0, HBSF_ST_SLEEP});
    // no-pin variant ignores the pin and brakes on the forced-low enable
    check({1'h0, nopin_state}, {1'h0, HBSF_ST_IDLE});
    check({nopin_link_if_i.bridge_output_a, nopin_link_if_i.bridge_output_b}, 4'h5);
    drive(0, HBSF_IF_PHEN, 1, 1, T + 10, 4'h9);
    drive(0, HBSF_IF_HALF, 0, 0, T + 10, 4'h5);
    // overtemp, supply lockout, overcurrent in turn
    for (int k = 0; k < 3; k++) begin
      drive(0, HBSF_IF_PWM, 0, 1, 5, 4'h6);
      overtemp_shutdown <= (k == 0);
      overtemp_hysteresis <= (k == 0);
      supply_low_lockout <= (k == 1);
      overcurrent_trip <= (k == 2);
      repeat (4) @(posedge clk_sys);
      check({3'h0, fault_active}, 4'h1);
      drive(0, HBSF_IF_PWM, 0, 1, 0, 4'h0);
      overtemp_shutdown <= 1'b0;
      supply_low_lockout <= 1'b0;
      overcurrent_trip <= 1'b0;
      drive(0, HBSF_IF_PWM, 0, 1, 4, (k == 1) ? 4'h6 : 4'h0);
      overtemp_hysteresis <= 1'b0;
      drive(0, HBSF_IF_PWM, 0, 1, T + 8, 4'h6);
    end
    repeat (4) @(posedge clk_sys);
    wrap_up();
  end
endmodule // hbridge_sleep_fault_control_tb
